// [ssmr_regs.sv]
// ssmr_regs: link health and sensor alarm status register group
// assumes status inputs are synchronous levels or one-cycle event strobes
`timescale 1ns/1ps
module ssmr_regs
	import ssmr_pkg::*;
(
	input  wire logic       clk,            // core clock, 200 MHz
	input  wire logic       rst_b,          // async reset, active low
	input  wire logic [7:0] addr,           // register offset
	input  wire logic [7:0] wdata,          // write data
	input  wire logic       wr,             // write strobe
	input  wire logic       rd,             // read strobe
	output logic      [7:0] rdata,          // read data, cycle after rd
	input  wire logic       rx_locked,      // remote deserializer lock
	input  wire logic       forward_pll_locked, // forward pll lock level
	input  wire logic       backchannel_link_valid, // link detect level
	input  wire logic       link_lost,      // link-detect lost condition
	input  wire logic       bc_error,       // back-channel error pulse
	input  wire logic       selftest_error, // self-test crc error pulse
	input  wire logic [3:0] pin_raw,        // general-purpose pin levels
	input  wire logic [3:0] pin_is_input,   // pin configured as input
	input  wire logic       init_cksum_ok,  // config checksum passed
	input  wire logic       init_done,      // power-up init complete
	input  wire logic       temp_over,      // temperature above limit
	input  wire logic       temp_under,     // temperature below limit
	input  wire logic       pin1_over,      // pin 1 voltage above limit
	input  wire logic       pin1_under,     // pin 1 voltage below limit
	input  wire logic       pin0_over,      // pin 0 voltage above limit
	input  wire logic       pin0_under,     // pin 0 voltage below limit
	input  wire logic [2:0] pin0_reading,   // 3-bit pin 0 sensor code
	output logic      [7:0] health,         // mirror of health register
	output logic            crc_fault_clear,     // pulse: crc clear
	output logic            selftest_tally_clear // pulse: tally clear
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	logic        rx_lock_q;
	logic        pll_q;
	logic        link_q;
	logic        lost_prev;
	logic        link_lost_flag;
	logic        selftest_crc_fault;
	logic        crc_fault;
	logic [3:0]  pin_levels;
	logic [7:0]  selftest_fault_tally;
	logic [15:0] crc_tally;
	logic [5:0]  alarm_q;
	logic [2:0]  pin0_peak_reading;
	logic [2:0]  pin0_trough_reading;
	logic [7:0]  bc_ctrl;
	logic [7:0]  next_rdata;
	logic        rd_alarms;
	logic        rd_v0;
	logic        pll_fell;
	logic        crc_clr_req;
	logic        bist_clr_req;

	assign rd_alarms    = rd && hit(addr, SSMR_ADDR_ALARMS);
	assign rd_v0        = rd && hit(addr, SSMR_ADDR_V0_EXT);
	assign pll_fell     = pll_q && !forward_pll_locked;
	assign crc_clr_req  = wr && hit(addr, SSMR_ADDR_BC_CTRL)
		&& wdata[SSMR_BIT_CRC_CLR];
	assign bist_clr_req = wr && hit(addr, SSMR_ADDR_BC_CTRL)
		&& wdata[SSMR_BIT_BIST_CLR];

	// control register; the clear bits fall back to zero next cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bc_ctrl <= SSMR_ZERO8;
		end else if (wr && hit(addr, SSMR_ADDR_BC_CTRL)) begin
			bc_ctrl <= wdata & SSMR_BC_WR_MASK;
		end else begin
			bc_ctrl[SSMR_BIT_CRC_CLR]  <= 1'b0;
			bc_ctrl[SSMR_BIT_BIST_CLR] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			crc_fault_clear      <= 1'b0;
			selftest_tally_clear <= 1'b0;
		end else begin
			crc_fault_clear      <= crc_clr_req;
			selftest_tally_clear <= bist_clr_req;
		end
	end

	// live status levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_lock_q <= 1'b0;
			pll_q     <= SSMR_PLL_RST;
			link_q    <= SSMR_LINK_RST;
			lost_prev <= 1'b0;
		end else begin
			rx_lock_q <= rx_locked;
			pll_q     <= forward_pll_locked;
			link_q    <= backchannel_link_valid;
			lost_prev <= link_lost;
		end
	end

	// set wins over clear so a change in the clearing cycle is kept
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link_lost_flag <= 1'b0;
		end else if (link_lost != lost_prev) begin
			link_lost_flag <= 1'b1;
		end else if (crc_clr_req || pll_fell) begin
			link_lost_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			crc_fault <= 1'b0;
		end else if (bc_error && backchannel_link_valid) begin
			crc_fault <= 1'b1;
		end else if (crc_clr_req) begin
			crc_fault <= 1'b0;
		end
	end

	// no clear control is given for the fault bit besides tally clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			selftest_crc_fault <= 1'b0;
		end else if (selftest_error) begin
			selftest_crc_fault <= 1'b1;
		end else if (bist_clr_req) begin
			selftest_crc_fault <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					pin_levels[g] <= 1'b0;
				end else if (pin_is_input[g]) begin
					pin_levels[g] <= pin_raw[g];
				end
			end
		end
	endgenerate

	ssmr_tally #(.W(8)) u_bist_tally (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (bist_clr_req),
		.inc   (selftest_error),
		.count (selftest_fault_tally)
	);

	// crc tally counts back-channel errors only while the link is valid, cleared with crc state
	ssmr_tally #(.W(16)) u_crc_tally (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (crc_clr_req),
		.inc   (bc_error && backchannel_link_valid),
		.count (crc_tally)
	);

	logic [5:0] alarm_cond;
	assign alarm_cond = {temp_over, temp_under, pin1_over, pin1_under,
		pin0_over, pin0_under};
	generate
		for (g = 0; g < 6; g++) begin : g_alarm
			ssmr_alarm u_alarm (
				.clk    (clk),
				.rst_b  (rst_b),
				.cond   (alarm_cond[g]),
				.rd_clr (rd_alarms),
				.flag   (alarm_q[g])
			);
		end
	endgenerate

	// track the extreme reading seen while the alarm stands
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin0_peak_reading <= SSMR_PEAK_RST;
		end else if (pin0_over) begin
			if (pin0_reading > pin0_peak_reading) begin
				pin0_peak_reading <= pin0_reading;
			end
		end else if (rd_v0) begin
			pin0_peak_reading <= SSMR_PEAK_RST;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin0_trough_reading <= SSMR_TROUGH_RST;
		end else if (pin0_under) begin
			if (pin0_reading < pin0_trough_reading) begin
				pin0_trough_reading <= pin0_reading;
			end
		end else if (rd_v0) begin
			pin0_trough_reading <= SSMR_TROUGH_RST;
		end
	end

	logic [7:0] health_val;
	always_comb begin
		health_val = SSMR_ZERO8;
		health_val[SSMR_BIT_RX_LOCK]    = rx_lock_q;
		health_val[SSMR_BIT_LINK_LOST]  = link_lost_flag;
		health_val[SSMR_BIT_BIST_FAULT] = selftest_crc_fault;
		health_val[SSMR_BIT_PLL_LOCK]   = pll_q;
		health_val[SSMR_BIT_CRC_FAULT]  = crc_fault;
		health_val[SSMR_BIT_LINK_VALID] = link_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			health <= {5'h00, SSMR_PLL_RST, 1'b0, SSMR_LINK_RST};
		end else begin
			health <= health_val;
		end
	end

	// unmapped offsets read as zero
	always_comb begin
		case (addr)
			SSMR_ADDR_BC_CTRL:  next_rdata = bc_ctrl;
			SSMR_ADDR_INIT:     next_rdata = {init_cksum_ok, init_done, 6'h00};
			SSMR_ADDR_HEALTH:   next_rdata = health_val;
			SSMR_ADDR_PINS:     next_rdata = {4'h0, pin_levels};
			SSMR_ADDR_BIST_CNT: next_rdata = selftest_fault_tally;
			SSMR_ADDR_CRC_LO:   next_rdata = crc_tally[7:0];
			SSMR_ADDR_CRC_HI:   next_rdata = crc_tally[15:8];
			SSMR_ADDR_ALARMS:   next_rdata = {2'h0, alarm_q};
			SSMR_ADDR_V0_EXT:   next_rdata = {1'b0, pin0_peak_reading, 1'b0,
				pin0_trough_reading};
			default:            next_rdata = SSMR_ZERO8;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= SSMR_ZERO8;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= SSMR_ZERO8;
		end
	end

	property p_link_lost_clear;
		@(posedge clk) disable iff (!rst_b)
		(crc_clr_req && link_lost == lost_prev) |=> !link_lost_flag;
	endproperty
	a_link_lost_clear: assert property (p_link_lost_clear)
		else $error("link lost flag not cleared");

	property p_link_lost_set;
		@(posedge clk) disable iff (!rst_b)
		(link_lost != lost_prev) |=> link_lost_flag;
	endproperty
	a_link_lost_set: assert property (p_link_lost_set)
		else $error("link lost flag not set on change");

	property p_crc_set;
		@(posedge clk) disable iff (!rst_b)
		(bc_error && backchannel_link_valid) |=> ##1 health[1];
	endproperty
	a_crc_set: assert property (p_crc_set)
		else $error("crc fault not reported");

	property p_crc_clear;
		@(posedge clk) disable iff (!rst_b)
		(crc_clr_req && !bc_error) |=> !crc_fault;
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("crc fault not cleared");

	sequence s_clr_write;
		bist_clr_req;
	endsequence
	sequence s_self_clear;
		bc_ctrl[SSMR_BIT_BIST_CLR] ##1 !bc_ctrl[SSMR_BIT_BIST_CLR];
	endsequence
	property p_bist_clr;
		@(posedge clk) disable iff (!rst_b)
		s_clr_write |=> s_self_clear;
	endproperty
	a_bist_clr: assert property (p_bist_clr)
		else $error("tally clear bit did not self clear");

	property p_tally_sat;
		@(posedge clk) disable iff (!rst_b)
		(selftest_fault_tally == 8'hFF && !bist_clr_req)
			|=> selftest_fault_tally == 8'hFF;
	endproperty
	a_tally_sat: assert property (p_tally_sat)
		else $error("tally wrapped");

	property p_pin_hold;
		@(posedge clk) disable iff (!rst_b)
		!pin_is_input[0] |=> pin_levels[0] == $past(pin_levels[0]);
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("output pin bit changed");

	property p_trough_read;
		@(posedge clk) disable iff (!rst_b)
		(rd_v0 && !pin0_under) |=> pin0_trough_reading == SSMR_TROUGH_RST;
	endproperty
	a_trough_read: assert property (p_trough_read)
		else $error("trough not restored on read");

	property p_alarm_read;
		@(posedge clk) disable iff (!rst_b)
		(rd_alarms && !temp_over) |=> !alarm_q[5];
	endproperty
	a_alarm_read: assert property (p_alarm_read)
		else $error("temperature alarm not cleared on read");
endmodule

// [ssmr_pkg.sv]
// ssmr_pkg: offsets, field positions, reset values for the status monitor
// assumes an 8-bit register port with byte offsets as printed
package ssmr_pkg;
	localparam logic [7:0] SSMR_ADDR_BC_CTRL   = 8'h49;
	localparam logic [7:0] SSMR_ADDR_INIT      = 8'h51;
	localparam logic [7:0] SSMR_ADDR_HEALTH    = 8'h52;
	localparam logic [7:0] SSMR_ADDR_PINS      = 8'h53;
	localparam logic [7:0] SSMR_ADDR_BIST_CNT  = 8'h54;
	localparam logic [7:0] SSMR_ADDR_CRC_LO    = 8'h55;
	localparam logic [7:0] SSMR_ADDR_CRC_HI    = 8'h56;
	localparam logic [7:0] SSMR_ADDR_ALARMS    = 8'h57;
	localparam logic [7:0] SSMR_ADDR_V0_EXT    = 8'h58;
	localparam int SSMR_BIT_RX_LOCK    = 6;
	localparam int SSMR_BIT_LINK_LOST  = 4;
	localparam int SSMR_BIT_BIST_FAULT = 3;
	localparam int SSMR_BIT_PLL_LOCK   = 2;
	localparam int SSMR_BIT_CRC_FAULT  = 1;
	localparam int SSMR_BIT_LINK_VALID = 0;
	localparam int SSMR_BIT_CRC_CLR    = 3;
	localparam int SSMR_BIT_BIST_CLR   = 5;
	localparam int SSMR_PEAK_LSB       = 4;
	localparam int SSMR_TROUGH_LSB     = 0;
	localparam logic [2:0] SSMR_PEAK_RST   = 3'h0;
	localparam logic [2:0] SSMR_TROUGH_RST = 3'h7;
	localparam logic [7:0] SSMR_ZERO8      = 8'h00;
	localparam logic       SSMR_PLL_RST    = 1'b1;
	localparam logic       SSMR_LINK_RST   = 1'b1;
	localparam logic [7:0] SSMR_BC_WR_MASK = 8'h3F;
endpackage

// [ssmr_tally.sv]
// ssmr_tally: saturating event counter with synchronous clear
// assumes clear and count are single-cycle qualified strobes
`timescale 1ns/1ps
module ssmr_tally #(
	parameter int W = 8
) (
	input  wire logic         clk,   // core clock
	input  wire logic         rst_b, // async reset, active low
	input  wire logic         clr,   // clear to zero
	input  wire logic         inc,   // count one event
	output logic [W-1:0]      count  // current tally
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (clr) begin
			count <= '0;
		end else if (inc && (count != {W{1'b1}})) begin
			// saturate: a wrapped count would hide a storm of errors
			count <= count + 1'b1;
		end
	end
endmodule

// [ssmr_alarm.sv]
// ssmr_alarm: one sticky clear-on-read alarm bit
// assumes rd_clr is a one-cycle strobe from the register read decode
`timescale 1ns/1ps
module ssmr_alarm (
	input  wire logic clk,    // core clock
	input  wire logic rst_b,  // async reset, active low
	input  wire logic cond,   // alarm condition level
	input  wire logic rd_clr, // register read clears
	output logic      flag    // sticky alarm
);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= 1'b0;
		end else if (cond) begin
			// a condition in the read cycle survives the clear
			flag <= 1'b1;
		end else if (rd_clr) begin
			flag <= 1'b0;
		end
	end
endmodule

// [ssmr_link_model.sv]
// ssmr_link_model: remote deserializer and back-channel as seen from here
// assumes the bench calls its tasks from one process, after reset release
`timescale 1ns/1ps
module ssmr_link_model (
	input  wire logic clk,                    // core clock
	output logic      rx_locked,              // remote lock level
	output logic      backchannel_link_valid, // link detect level
	output logic      link_lost,              // link lost condition level
	output logic      bc_error,               // back-channel error pulse
	output logic      selftest_error          // self-test crc error pulse
);
	initial begin
		rx_locked = 1'b0;
		backchannel_link_valid = 1'b1;
		link_lost = 1'b0;
		bc_error = 1'b0;
		selftest_error = 1'b0;
	end

	// levels change just after an edge, then one edge lets them land
	task automatic set_state(input logic lock, input logic valid,
			input logic lost);
		@(posedge clk);
		rx_locked <= lock;
		backchannel_link_valid <= valid;
		link_lost <= lost;
		@(posedge clk);
	endtask

	// gap 0 holds the strobe high, one error per cycle, the fastest case
	task automatic send_errors(input int n, input logic bist, input int gap);
		repeat (n) begin
			@(posedge clk);
			if (bist) begin
				selftest_error <= 1'b1;
			end else begin
				bc_error <= 1'b1;
			end
			if (gap > 0) begin
				@(posedge clk);
				bc_error <= 1'b0;
				selftest_error <= 1'b0;
				repeat (gap - 1) @(posedge clk);
			end
		end
		@(posedge clk);
		bc_error <= 1'b0;
		selftest_error <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
endmodule

// [ssmr_regs_tb_top.sv]
// ssmr_regs_tb_top: register-level checks of the status monitor group
// assumes ssmr_pkg, ssmr_regs and ssmr_link_model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	$display("unexpected %s: expected %h seen %h", nm, e, g); \
	error_cnt++; end end
module ssmr_regs_tb_top
	import ssmr_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       pll = 1'b1;
	logic [3:0] pin_raw = 4'hA;
	logic [3:0] pin_is_input = 4'hF;
	logic [5:0] alarm = 6'h00;
	logic [2:0] reading = 3'h4;
	logic [7:0] rdata;
	logic [7:0] health;
	logic       crc_fault_clear;
	logic       selftest_tally_clear;
	logic       rx_locked;
	logic       link_valid;
	logic       link_lost;
	logic       bc_error;
	logic       selftest_error;
	logic [1:0] pulses;
	int         error_cnt = 0;
	int         num_checks = 0;

	initial begin
		forever #2.5 clk = ~clk;
	end

	ssmr_link_model u_ssmr_link_model (
		.clk                    (clk),
		.rx_locked              (rx_locked),
		.backchannel_link_valid (link_valid),
		.link_lost              (link_lost),
		.bc_error               (bc_error),
		.selftest_error         (selftest_error)
	);

	ssmr_regs u_ssmr_regs (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rx_locked(rx_locked),
		.forward_pll_locked(pll), .backchannel_link_valid(link_valid),
		.link_lost(link_lost), .bc_error(bc_error),
		.selftest_error(selftest_error), .pin_raw(pin_raw),
		.pin_is_input(pin_is_input), .init_cksum_ok(1'b1),
		.init_done(1'b0), .temp_over(alarm[5]), .temp_under(alarm[4]),
		.pin1_over(alarm[3]), .pin1_under(alarm[2]),
		.pin0_over(alarm[1]), .pin0_under(alarm[0]),
		.pin0_reading(reading), .health(health),
		.crc_fault_clear(crc_fault_clear),
		.selftest_tally_clear(selftest_tally_clear)
	);

	// pulses are caught in the cycle after the write strobe, their only one
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
		pulses = {crc_fault_clear, selftest_tally_clear};
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK($sformatf("reg %h", a), e, rdata)
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		@(posedge clk);
		#1;
		`CHK("health in reset", 8'h05, health)
		`CHK("rdata in reset", 8'h00, rdata)
		@(posedge clk);
		rst_b <= 1'b1;
		chk_rd(SSMR_ADDR_HEALTH, 8'h05);
		chk_rd(SSMR_ADDR_INIT, 8'h80);
		chk_rd(SSMR_ADDR_BIST_CNT, 8'h00);
		chk_rd(SSMR_ADDR_CRC_LO, 8'h00);
		chk_rd(SSMR_ADDR_CRC_HI, 8'h00);
		chk_rd(SSMR_ADDR_V0_EXT, 8'h07);
		chk_rd(8'h60, 8'h00);
		wr_reg(SSMR_ADDR_HEALTH, 8'hFF);
		chk_rd(SSMR_ADDR_HEALTH, 8'h05);
		u_ssmr_link_model.set_state(1'b1, 1'b0, 1'b0);
		chk_rd(SSMR_ADDR_HEALTH, 8'h44);
		u_ssmr_link_model.send_errors(1, 1'b0, 1);
		chk_rd(SSMR_ADDR_HEALTH, 8'h44);
		chk_rd(SSMR_ADDR_CRC_LO, 8'h00);
		u_ssmr_link_model.set_state(1'b1, 1'b1, 1'b1);
		u_ssmr_link_model.set_state(1'b1, 1'b1, 1'b0);
		u_ssmr_link_model.send_errors(3, 1'b0, 2);
		chk_rd(SSMR_ADDR_HEALTH, 8'h57);
		`CHK("health port", 8'h57, health)
		chk_rd(SSMR_ADDR_CRC_LO, 8'h03);
		chk_rd(SSMR_ADDR_CRC_HI, 8'h00);
		wr_reg(SSMR_ADDR_BC_CTRL, 8'h0D);
		`CHK("clear pulses", 2'b10, pulses)
		chk_rd(SSMR_ADDR_BC_CTRL, 8'h05);
		chk_rd(SSMR_ADDR_HEALTH, 8'h45);
		chk_rd(SSMR_ADDR_CRC_LO, 8'h00);
		u_ssmr_link_model.send_errors(3, 1'b1, 1);
		chk_rd(SSMR_ADDR_BIST_CNT, 8'h03);
		chk_rd(SSMR_ADDR_HEALTH, 8'h4D);
		wr_reg(SSMR_ADDR_BC_CTRL, 8'h20);
		`CHK("clear pulses", 2'b01, pulses)
		chk_rd(SSMR_ADDR_BIST_CNT, 8'h00);
		chk_rd(SSMR_ADDR_HEALTH, 8'h45);
		u_ssmr_link_model.send_errors(260, 1'b1, 0);
		chk_rd(SSMR_ADDR_BIST_CNT, 8'hFF);
		u_ssmr_link_model.set_state(1'b1, 1'b1, 1'b1);
		@(posedge clk);
		pll <= 1'b0;
		repeat (2) @(posedge clk);
		chk_rd(SSMR_ADDR_HEALTH, 8'h49);
		`CHK("health port", 8'h49, health)
		@(posedge clk);
		pll <= 1'b1;
		repeat (2) @(posedge clk);
		chk_rd(SSMR_ADDR_HEALTH, 8'h4D);
		chk_rd(SSMR_ADDR_PINS, 8'h0A);
		@(posedge clk);
		pin_is_input <= 4'hE;
		pin_raw <= 4'h5;
		repeat (2) @(posedge clk);
		chk_rd(SSMR_ADDR_PINS, 8'h04);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			alarm <= 6'h01 << i;
			@(posedge clk);
			alarm <= 6'h00;
			chk_rd(SSMR_ADDR_ALARMS, 8'h01 << i);
			chk_rd(SSMR_ADDR_ALARMS, 8'h00);
		end
		chk_rd(SSMR_ADDR_V0_EXT, 8'h44);
		chk_rd(SSMR_ADDR_V0_EXT, 8'h07);
		@(posedge clk);
		alarm <= 6'h02;
		reading <= 3'h5;
		@(posedge clk);
		reading <= 3'h3;
		@(posedge clk);
		alarm <= 6'h01;
		reading <= 3'h2;
		@(posedge clk);
		reading <= 3'h6;
		@(posedge clk);
		alarm <= 6'h00;
		repeat (2) @(posedge clk);
		chk_rd(SSMR_ADDR_V0_EXT, 8'h52);
		test_done();
	end

	// the sequence needs under 1000 cycles; five times that means a hang
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		test_done();
	end
endmodule
